// *** verilog/pmbr_pkg.sv ***
// Constants, states and carrier types for the burst read tail.
// Assumes a single PCI clock domain shared by the bus and the local side.
package pmbr_pkg;
    localparam logic [7:0] CTRL_OFFSET = 8'h00;
    localparam logic [7:0] STATUS_OFFSET = 8'h04;
    localparam logic [31:0] CTRL_RESET = 32'h00000001;
    localparam int CTRL_ENABLE_BIT = 0;
    localparam int TSR_DATA_MODE_BIT = 3;
    localparam int TSR_SUCCESS_BIT = 8;
    localparam int TSR_ACK64_BIT = 9;
    localparam int TSR_WIDTH = 10;
    localparam int BUF_DEPTH = 2;
    localparam logic [1:0] BUF_FULL_COUNT = 2'h2;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_ADDR = 3'b001,
        ST_DATA = 3'b010,
        ST_LAST = 3'b011,
        ST_END = 3'b100,
        ST_DRAIN = 3'b101
    } pmbr_state_type;

    typedef struct packed {
        logic ackN;
        logic strobeN;
        logic lowAckN;
        logic highAckN;
    } pmbr_local_type;

    localparam pmbr_local_type LOCAL_IDLE = 4'hF;
endpackage

// *** verilog/pmbr_core.sv ***
// Master-mode burst memory read tail: data phases, termination, waits.
// Assumes PCI pins and local logic all run on mclk; pads resolve enables.
//
// Implementation choices: the register offsets and the APB interface to the registers.
`timescale 1ns/1ns
module pmbr_core import pmbr_pkg::*; (
    input wire logic mclk,
    input wire logic srst,
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic trdyN,
    input wire logic devselN,
    input wire logic ack64N,
    input wire logic [63:0] adIn,
    output logic frameN,
    output logic frameOe,
    output logic req64N,
    output logic req64Oe,
    output logic irdyN,
    output logic irdyOe,
    input wire logic request32bitN,
    input wire logic request64bitN,
    input wire logic lastWordRequestN,
    input wire logic localReadyN,
    output logic masterDataAckN,
    output logic masterTransferStrobeN,
    output logic lowDwordAckN,
    output logic highDwordAckN,
    output logic [63:0] readDataOut,
    output logic [TSR_WIDTH-1:0] masterStatusVector
);
    pmbr_state_type stateQ, stateD;
    logic frameNQ, frameND, frameOeQ, frameOeD, req64NQ, req64ND, req64OeQ, req64OeD;
    logic irdyNQ, irdyND, irdyOeQ, irdyOeD, firstQ, firstD, is64Q, is64D;
    logic dataModeQ, dataModeD, successQ, successD, ack64Q, ack64D;
    logic [63:0] memQ [BUF_DEPTH];
    logic [63:0] memD [BUF_DEPTH];
    logic wrPtrQ, wrPtrD, rdPtrQ, rdPtrD, dwordSelQ, dwordSelD;
    logic [1:0] countQ, countD;
    logic [63:0] readDataQ, readDataD;
    pmbr_local_type localQ, localD;
    logic [31:0] ctrlQ, ctrlD, prdataQ, prdataD;
    logic preadyQ, preadyD, pslverrQ, pslverrD;
    logic phaseDone, push, pop, room;

    // A data phase completes at the edge where both ready lines are low.
    assign phaseDone = irdyOeQ && !irdyNQ && !trdyN;
    assign push = phaseDone;
    assign pop = !localQ.strobeN;

    // Two-entry buffer between the PCI data lines and the local side.
    always_comb begin
        memD = memQ;
        wrPtrD = wrPtrQ;
        rdPtrD = rdPtrQ;
        countD = countQ;
        if (push) begin
            memD[wrPtrQ] = is64Q ? adIn : {32'h00000000, adIn[31:0]};
            wrPtrD = !wrPtrQ;
        end
        if (pop) begin
            rdPtrD = !rdPtrQ;
        end
        countD = 2'(countQ + {1'b0, push} - {1'b0, pop});
        readDataD = memD[rdPtrD];
    end

    // Bus-side sequencing from address phase to release of the lines.
    always_comb begin
        stateD = stateQ;
        frameND = frameNQ;
        frameOeD = frameOeQ;
        req64ND = req64NQ;
        req64OeD = req64OeQ;
        irdyND = irdyNQ;
        irdyOeD = irdyOeQ;
        firstD = firstQ;
        is64D = is64Q;
        dataModeD = dataModeQ;
        room = countD < BUF_FULL_COUNT;
        successD = phaseDone;
        ack64D = dataModeQ && !ack64N && !devselN;
        case (stateQ)
            ST_IDLE: begin
                if (ctrlQ[CTRL_ENABLE_BIT] && (!request32bitN || !request64bitN)) begin
                    is64D = !request64bitN && request32bitN;
                    frameND = 1'b0;
                    frameOeD = 1'b1;
                    req64ND = !is64D;
                    req64OeD = 1'b1;
                    irdyND = 1'b1;
                    irdyOeD = 1'b1;
                    stateD = ST_ADDR;
                end
            end
            ST_ADDR: begin
                irdyND = 1'b0;
                firstD = 1'b1;
                dataModeD = 1'b1;
                if (!lastWordRequestN) begin
                    frameND = 1'b1;
                    req64ND = 1'b1;
                    stateD = ST_LAST;
                end else begin
                    stateD = ST_DATA;
                end
            end
            ST_DATA: begin
                if (phaseDone) begin
                    firstD = 1'b0;
                end
                if (phaseDone && !lastWordRequestN) begin
                    frameND = 1'b1;
                    req64ND = 1'b1;
                    irdyND = !room;
                    stateD = ST_LAST;
                end else begin
                    irdyND = !(room && ((firstQ && !phaseDone) || !localReadyN));
                end
            end
            ST_LAST: begin
                if (phaseDone) begin
                    irdyND = 1'b1;
                    stateD = ST_END;
                end else begin
                    irdyND = !room;
                end
            end
            ST_END: begin
                frameOeD = 1'b0;
                req64OeD = 1'b0;
                irdyOeD = 1'b0;
                stateD = ST_DRAIN;
            end
            ST_DRAIN: begin
                if (countD == 2'h0) begin
                    dataModeD = 1'b0;
                    stateD = ST_IDLE;
                end
            end
            default: begin
                stateD = ST_IDLE;
            end
        endcase
    end

    // Local-side handshake; each output is registered.
    always_comb begin
        localD = LOCAL_IDLE;
        dwordSelD = dwordSelQ;
        localD.ackN = !(dataModeD && countD != 2'h0);
        localD.strobeN = localD.ackN || localReadyN;
        if (stateQ == ST_IDLE) begin
            dwordSelD = 1'b0;
        end else if (!localD.strobeN && !is64Q) begin
            dwordSelD = !dwordSelQ;
        end
        localD.lowAckN = localD.strobeN || (!is64Q && dwordSelQ);
        localD.highAckN = localD.strobeN || (!is64Q && !dwordSelQ);
    end

    // APB slave with one wait state per access.
    always_comb begin
        ctrlD = ctrlQ;
        preadyD = psel && penable && !preadyQ;
        prdataD = 32'h00000000;
        pslverrD = 1'b0;
        if (preadyD) begin
            case (paddr)
                CTRL_OFFSET: prdataD = ctrlQ;
                STATUS_OFFSET: prdataD = {22'h0, masterStatusVector[TSR_WIDTH-1:4],
                    dataModeQ, stateQ};
                default: pslverrD = 1'b1;
            endcase
        end
        if (psel && penable && preadyQ && pwrite && paddr == CTRL_OFFSET) begin
            ctrlD = pwdata;
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            stateQ <= ST_IDLE;
            frameNQ <= 1'b1;
            frameOeQ <= 1'b0;
            req64NQ <= 1'b1;
            req64OeQ <= 1'b0;
            irdyNQ <= 1'b1;
            irdyOeQ <= 1'b0;
            firstQ <= 1'b0;
            is64Q <= 1'b0;
            dataModeQ <= 1'b0;
            successQ <= 1'b0;
            ack64Q <= 1'b0;
            memQ[0] <= 64'h0000000000000000;
            memQ[1] <= 64'h0000000000000000;
            wrPtrQ <= 1'b0;
            rdPtrQ <= 1'b0;
            countQ <= 2'h0;
            readDataQ <= 64'h0000000000000000;
            dwordSelQ <= 1'b0;
            localQ <= LOCAL_IDLE;
            ctrlQ <= CTRL_RESET;
            prdataQ <= 32'h00000000;
            preadyQ <= 1'b0;
            pslverrQ <= 1'b0;
        end else begin
            stateQ <= stateD;
            frameNQ <= frameND;
            frameOeQ <= frameOeD;
            req64NQ <= req64ND;
            req64OeQ <= req64OeD;
            irdyNQ <= irdyND;
            irdyOeQ <= irdyOeD;
            firstQ <= firstD;
            is64Q <= is64D;
            dataModeQ <= dataModeD;
            successQ <= successD;
            ack64Q <= ack64D;
            memQ <= memD;
            wrPtrQ <= wrPtrD;
            rdPtrQ <= rdPtrD;
            countQ <= countD;
            readDataQ <= readDataD;
            dwordSelQ <= dwordSelD;
            localQ <= localD;
            ctrlQ <= ctrlD;
            prdataQ <= prdataD;
            preadyQ <= preadyD;
            pslverrQ <= pslverrD;
        end
    end

    assign prdata = prdataQ;
    assign pready = preadyQ;
    assign pslverr = pslverrQ;
    assign frameN = frameNQ;
    assign frameOe = frameOeQ;
    assign req64N = req64NQ;
    assign req64Oe = req64OeQ;
    assign irdyN = irdyNQ;
    assign irdyOe = irdyOeQ;
    assign masterDataAckN = localQ.ackN;
    assign masterTransferStrobeN = localQ.strobeN;
    assign lowDwordAckN = localQ.lowAckN;
    assign highDwordAckN = localQ.highAckN;
    assign readDataOut = readDataQ;
    assign masterStatusVector = {ack64Q, successQ, 4'h0, dataModeQ, 3'h0};

    default clocking @(posedge mclk); endclocking
    default disable iff (srst);

    last_frame_a: assert property ((stateQ == ST_DATA && phaseDone && !lastWordRequestN && room)
        |=> frameNQ && !irdyNQ && irdyOeQ) else $error("Frame not released on last phase.");
    data_ack_a: assert property (phaseDone |=> !masterDataAckN)
        else $error("Latched data not acknowledged.");
    strobe_cause_a: assert property (!masterTransferStrobeN |-> $past(!localReadyN) && !masterDataAckN)
        else $error("Strobe without ready and acknowledge.");
    dword_ack_a: assert property ((!masterTransferStrobeN && is64Q) |-> !lowDwordAckN && !highDwordAckN)
        else $error("Wide word lacks both dword acknowledges.");
    success_bit_a: assert property (phaseDone |=> masterStatusVector[TSR_SUCCESS_BIT])
        else $error("Success bit missing after phase.");
    end_release_a: assert property ((stateQ == ST_LAST && phaseDone) |=> irdyNQ ##1 !irdyOeQ && !frameOeQ)
        else $error("Lines not released after final phase.");
    mode_clear_a: assert property ($fell(masterStatusVector[TSR_DATA_MODE_BIT])
        |-> masterDataAckN && masterTransferStrobeN) else $error("Handshake outlives data mode.");
    req64_off_a: assert property (!is64Q |-> !(req64OeQ && !req64NQ))
        else $error("Req64 asserted on narrow request.");
    local_wait_a: assert property ((stateQ == ST_DATA && !firstQ && localReadyN && lastWordRequestN)
        |=> masterTransferStrobeN && irdyNQ) else $error("Local wait not honoured.");
    target_wait_a: assert property ((dataModeQ && trdyN && countQ == 2'h0) |=> masterDataAckN)
        else $error("Acknowledge during target wait.");
    mode_set_a: assert property (stateQ == ST_ADDR |=> masterStatusVector[TSR_DATA_MODE_BIT])
        else $error("Data mode not set.");
    two_phase_a: assert property ((stateQ == ST_LAST && phaseDone) |=> !phaseDone [*3])
        else $error("Extra phase after final one.");
    target_strobe_a: assert property ((dataModeQ && trdyN && countQ == 2'h0)
        |=> masterTransferStrobeN) else $error("Strobe during target wait.");
    phase_need_a: assert property (masterStatusVector[TSR_SUCCESS_BIT]
        |-> $past(irdyOe && !irdyN && !trdyN)) else $error("Success bit without completed phase.");
    narrow_upper_a: assert property ((!masterTransferStrobeN && !is64Q)
        |-> readDataOut[63:32] == 32'h00000000) else $error("Upper half not cleared on narrow word.");
endmodule

// *** test/pmbr_target_model.sv ***
// PCI target model: claims every transaction and answers, optionally with waits.
// Assumes the bench resolves the frame, irdy and req64 wires with pull-ups.
`timescale 1ns/1ns
module pmbr_target_model (
    input wire logic mclk,
    input wire logic srst,
    input wire logic frameW,
    input wire logic irdyW,
    input wire logic req64W,
    input wire logic stallIn,
    output logic trdyN,
    output logic devselN,
    output logic ack64N,
    output logic [63:0] adIn
);
    logic claimQ;
    logic wideQ;
    logic stallQ;
    logic [31:0] cntQ;
    logic [63:0] word;
    assign word = {32'h20000000 + cntQ, 32'h10000000 + cntQ};
    assign devselN = ~claimQ;
    assign ack64N = ~(claimQ & wideQ);
    assign trdyN = ~(claimQ & ~stallQ);
    // Undriven data lines show the inverse of the word, not a stale copy.
    assign adIn = trdyN ? ~word : word;
    always_ff @(posedge mclk) begin
        if (srst) begin
            claimQ <= 1'h0;
            stallQ <= 1'h0;
        end else begin
            claimQ <= ~frameW | (claimQ & ~(frameW & ~irdyW & ~trdyN));
            stallQ <= stallIn;
        end
        if (!claimQ) begin
            wideQ <= ~req64W;
            cntQ <= 32'h00000000;
        end else if (!irdyW && !trdyN) begin
            cntQ <= cntQ + 32'h00000001;
        end
    end
endmodule

// *** test/pci_master_burst_read_tail_tb_top.sv ***
// Bench for the burst read tail: APB register checks and burst reads.
// Assumes the target model in its own file and wires with pull-ups.
`timescale 1ns/1ns
module pci_master_burst_read_tail_tb_top import pmbr_pkg::*; ;
    logic mclk = 1'h0;
    logic srst = 1'h1;
    logic [7:0] paddr = 8'h00;
    logic psel = 1'h0;
    logic penable = 1'h0;
    logic pwrite = 1'h0;
    logic [31:0] pwdata = 32'h00000000;
    logic request32bitN = 1'h1;
    logic request64bitN = 1'h1;
    logic lastWordRequestN = 1'h1;
    logic localReadyN = 1'h0;
    logic stallIn = 1'h0;
    logic [31:0] prdata;
    logic pready, pslverr, trdyN, devselN, ack64N, frameN, frameOe, req64N, req64Oe, irdyN, irdyOe;
    logic masterDataAckN, masterTransferStrobeN, lowDwordAckN, highDwordAckN;
    logic [63:0] adIn, readDataOut;
    logic [TSR_WIDTH-1:0] masterStatusVector;
    logic frameW, irdyW, req64W;
    int errTotal = 0, nCompared = 0, cycles = 0, seed = 61, phases = 0, after = 0;
    logic wideRun = 1'h1, lowNext = 1'h1, noisy = 1'h0, lastSeen = 1'h0, modeSeen = 1'h0;
    logic prevReadyN = 1'h1, prevDone = 1'h0, prevMode = 1'h0, prevLast = 1'h0;
    logic [63:0] expQ [$];
    logic [63:0] e;
    assign frameW = frameOe ? frameN : 1'h1;
    assign irdyW = irdyOe ? irdyN : 1'h1;
    assign req64W = req64Oe ? req64N : 1'h1;
    always #10 mclk = ~mclk;
    pmbr_core DUT (.mclk, .srst, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr,
        .trdyN, .devselN, .ack64N, .adIn, .frameN, .frameOe, .req64N, .req64Oe, .irdyN, .irdyOe,
        .request32bitN, .request64bitN, .lastWordRequestN, .localReadyN, .masterDataAckN,
        .masterTransferStrobeN, .lowDwordAckN, .highDwordAckN, .readDataOut, .masterStatusVector);
    pmbr_target_model target (.mclk, .srst, .frameW, .irdyW, .req64W, .stallIn, .trdyN, .devselN,
        .ack64N, .adIn);
    task automatic compareWord(input logic [63:0] got, input logic [63:0] exp);
        nCompared++;
        if (got !== exp) begin
            errTotal++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic compareFlag(input logic got, input logic exp);
        compareWord({63'h0, got}, {63'h0, exp});
    endtask
    task automatic summarize;
        if (errTotal == 0 && nCompared > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd, input logic [31:0] rd,
        input logic err);
        psel <= 1'h1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge mclk);
        penable <= 1'h1;
        do @(posedge mclk); while (pready !== 1'h1);
        compareFlag(pslverr, err);
        if (!wr) compareWord({32'h0, prdata}, {32'h0, rd});
        psel <= 1'h0;
        penable <= 1'h0;
        @(posedge mclk);
    endtask
    task automatic runBurst(input logic wide, input int words);
        wideRun = wide;
        lowNext = 1'h1;
        lastSeen = 1'h0;
        modeSeen = 1'h0;
        after = 0;
        phases = 0;
        request64bitN <= ~wide;
        request32bitN <= wide;
        while (frameOe !== 1'h1) @(posedge mclk);
        request64bitN <= 1'h1;
        request32bitN <= 1'h1;
        while (phases < words - 1) @(posedge mclk);
        lastWordRequestN <= 1'h0;
        while (frameOe !== 1'h0 || irdyOe !== 1'h0 || masterStatusVector[TSR_DATA_MODE_BIT] !== 1'h0)
            @(posedge mclk);
        lastWordRequestN <= 1'h1;
        compareWord({61'h0, frameOe, irdyOe, req64Oe}, 64'h0);
        compareFlag(after > 2, 1'h0);
        compareFlag(modeSeen, 1'h1);
        compareWord(64'(expQ.size()), 64'h0);
        @(posedge mclk);
    endtask
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 20000) begin
            errTotal++;
            summarize();
        end
        localReadyN <= (noisy && frameW === 1'h0 && lastWordRequestN) ? 1'($random(seed)) : 1'h0;
        stallIn <= noisy ? 1'($random(seed)) : 1'h0;
        if (!srst) begin
            compareFlag(masterTransferStrobeN, prevReadyN | masterDataAckN);
            compareFlag(masterStatusVector[TSR_SUCCESS_BIT], prevDone);
            if (prevLast) compareWord({62'h0, frameW, req64W}, 64'h3);
            if (!wideRun) compareFlag(req64W, 1'h1);
            if (prevMode && !masterStatusVector[TSR_DATA_MODE_BIT])
                compareWord({62'h0, masterDataAckN, masterTransferStrobeN}, 64'h3);
            if (!masterTransferStrobeN) begin
                e = expQ.size() ? expQ.pop_front() : ~readDataOut;
                if (wideRun) begin
                    compareWord(readDataOut, e);
                    compareWord({62'h0, lowDwordAckN, highDwordAckN}, 64'h0);
                end else begin
                    compareWord({32'h0, readDataOut[31:0]}, {32'h0, e[31:0]});
                    compareWord({62'h0, lowDwordAckN, highDwordAckN}, lowNext ? 64'h1 : 64'h2);
                    lowNext = ~lowNext;
                end
            end
            modeSeen = modeSeen | masterStatusVector[TSR_DATA_MODE_BIT];
            prevDone = !irdyW && !trdyN;
            if (prevDone) begin
                expQ.push_back(wideRun ? adIn : {32'h0, adIn[31:0]});
                phases++;
                lastSeen = lastSeen | !lastWordRequestN;
                if (lastSeen) after++;
            end
            prevLast = prevDone && !lastWordRequestN;
            prevReadyN = localReadyN;
            prevMode = masterStatusVector[TSR_DATA_MODE_BIT];
        end
    end
    initial begin
        repeat (8) @(posedge mclk);
        srst <= 1'h0;
        @(posedge mclk);
        apb(1'h0, CTRL_OFFSET, 32'h0, CTRL_RESET, 1'h0);
        apb(1'h0, STATUS_OFFSET, 32'h0, 32'h0, 1'h0);
        apb(1'h1, 8'h0C, $random(seed), 32'h0, 1'h1);
        apb(1'h0, 8'h0C, 32'h0, 32'h0, 1'h1);
        apb(1'h1, CTRL_OFFSET, CTRL_RESET, 32'h0, 1'h0);
        apb(1'h0, CTRL_OFFSET, 32'h0, CTRL_RESET, 1'h0);
        for (int i = 0; i < 10; i++) begin
            noisy = i >= 4;
            runBurst(i[0], (i % 4 == 0) ? 1 : 3 + i);
        end
        summarize();
    end
endmodule
